// ---- include/lamp_pkg.sv ----
package lamp_pkg;
  localparam int unsigned CLK_HZ          = 10_000_000;
  localparam int unsigned BLINK_ON_MS     = 1000;
  localparam int unsigned BLINK_OFF_MS    = 1000;
  localparam int unsigned PAUSE_MS        = 5000;
  localparam int unsigned MS_CYCLES       = CLK_HZ / 1000;
  localparam int unsigned BLINK_ON_CYC    = BLINK_ON_MS * MS_CYCLES;
  localparam int unsigned PAUSE_CYC       = PAUSE_MS * MS_CYCLES;
  localparam int unsigned STEP_MS         = 500;
  localparam int unsigned ACT_HALF_MS     = 50;
  localparam int unsigned CODE_W          = 3;
  localparam logic [2:0]  CODE_NONE       = 3'h0;
  localparam logic [2:0]  CODE_DATA_BUS   = 3'h1;
  localparam logic [2:0]  CODE_ADDR_BUS   = 3'h2;
  localparam logic [2:0]  CODE_DATA_RW    = 3'h3;
  localparam logic [2:0]  CODE_REG_SINGLE = 3'h4;
  localparam logic [2:0]  CODE_REG_BLOCK  = 3'h5;
  localparam logic [2:0]  CODE_FLASH_CRC  = 3'h6;
  // AHB-Lite register map
  localparam logic [7:0]  CTRL_OFS        = 8'h00;
  localparam logic [7:0]  STAT_OFS        = 8'h04;
  localparam logic [7:0]  IRQ_STAT_OFS    = 8'h08;
  localparam logic [7:0]  IRQ_MASK_OFS    = 8'h0C;
  localparam int unsigned CTRL_RUN_BIT    = 0;
  localparam int unsigned IRQ_FAIL_BIT    = 0;
  localparam int unsigned IRQ_RUN_BIT     = 1;
  localparam int unsigned IRQ_LINK_BIT    = 2;
  localparam logic [31:0] CTRL_RST        = 32'h0000_0001;
  localparam logic [2:0]  IRQ_MASK_RST    = 3'h0;
endpackage

// ---- core/lamp_blinker.sv ----
`timescale 1ns/10ps
`default_nettype none
module lamp_blinker
  import lamp_pkg::*;
#(
  parameter int unsigned ON_CYC    = BLINK_ON_CYC,
  parameter int unsigned PAUSE_CYCS = PAUSE_CYC
) (
  input  wire logic              clk_i,
  input  wire logic              rst_n_i,
  input  wire logic [CODE_W-1:0] code_i,
  output logic                   lamp_o
);
  typedef enum logic [1:0] {B_IDLE, B_ON, B_OFF, B_PAUSE} blink_e;
  blink_e       state_ff;
  logic [31:0]  tick_ff;
  logic [2:0]   count_ff;

  // Tick counter sets blink and pause lengths; group restarts after pause
  always_ff @(posedge clk_i or negedge rst_n_i) begin
    if (!rst_n_i) begin
      state_ff <= B_IDLE;
      tick_ff  <= 32'h0;
      count_ff <= 3'h0;
    end else if (code_i == CODE_NONE) begin
      state_ff <= B_IDLE;
      tick_ff  <= 32'h0;
      count_ff <= 3'h0;
    end else begin
      case (state_ff)
        B_IDLE: begin
          state_ff <= B_ON;
          tick_ff  <= 32'h0;
          count_ff <= 3'h0;
        end
        B_ON: begin
          if (tick_ff == ON_CYC - 1) begin
            state_ff <= B_OFF;
            tick_ff  <= 32'h0;
            count_ff <= count_ff + 3'h1;
          end else begin
            tick_ff <= tick_ff + 32'h1;
          end
        end
        B_OFF: begin
          if (tick_ff == ON_CYC - 1) begin
            tick_ff <= 32'h0;
            if (count_ff >= code_i) begin
              state_ff <= B_PAUSE;
            end else begin
              state_ff <= B_ON;
            end
          end else begin
            tick_ff <= tick_ff + 32'h1;
          end
        end
        B_PAUSE: begin
          if (tick_ff == PAUSE_CYCS - 1) begin
            state_ff <= B_ON;
            tick_ff  <= 32'h0;
            count_ff <= 3'h0;
          end else begin
            tick_ff <= tick_ff + 32'h1;
          end
        end
        default: state_ff <= B_IDLE;
      endcase
    end
  end

  always_ff @(posedge clk_i or negedge rst_n_i) begin
    if (!rst_n_i) begin
      lamp_o <= 1'b0;
    end else begin
      lamp_o <= (code_i != CODE_NONE) && (state_ff == B_ON);
    end
  end

  AST_RED_DARK_NO_ERR: assert property (@(posedge clk_i) disable iff (!rst_n_i)
    (code_i == CODE_NONE) [*2] |-> !lamp_o)
    else $error("red lamp lit without error");
  AST_COUNT_BOUND: assert property (@(posedge clk_i) disable iff (!rst_n_i)
    (state_ff == B_PAUSE) |-> (count_ff == code_i))
    else $error("blink count differs from code");
endmodule
`default_nettype wire

// ---- core/network_board_status_lamps.sv ----
// Local design decisions: the register offsets and register access over AHB-Lite.
`timescale 1ns/10ps
`default_nettype none
module network_board_status_lamps
  import lamp_pkg::*;
#(
  parameter int unsigned ON_CYC     = BLINK_ON_CYC,
  parameter int unsigned PAUSE_CYCS = PAUSE_CYC,
  parameter int unsigned STEP_CYC   = STEP_MS * MS_CYCLES,
  parameter int unsigned ACT_CYC    = ACT_HALF_MS * MS_CYCLES
) (
  input  wire logic        CLK_I,
  input  wire logic        RSTN_I,
  input  wire logic        LINK_UP_I,
  input  wire logic        TRAFFIC_I,
  input  wire logic        FULL_DUPLEX_I,
  input  wire logic        SPEED_100_I,
  input  wire logic        SELFTEST_BUSY_I,
  input  wire logic        SELFTEST_DONE_I,
  input  wire logic [2:0]  FAIL_CODE_I,
  input  wire logic        HSEL,
  input  wire logic [31:0] HADDR,
  input  wire logic [1:0]  HTRANS,
  input  wire logic        HWRITE,
  input  wire logic [2:0]  HSIZE,
  input  wire logic [31:0] HWDATA,
  input  wire logic        HREADY,
  output logic [31:0]      HRDATA,
  output logic             HREADYOUT,
  output logic             HRESP,
  output logic             ACT_LAMP_O,
  output logic             DUPLEX_LAMP_O,
  output logic             SPEED_LAMP_O,
  output logic             SELFTEST_LAMP_O,
  output logic             RUN_LAMP_O,
  output logic             FAIL_LAMP_O,
  output logic             IRQ_O
);
  typedef enum logic [2:0] {S_ONE, S_TWO, S_THREE, S_FOUR, S_RUN} step_e;

  logic        rst_a_ff;
  logic        rst_n;
  step_e       step_ff;
  logic [31:0] step_tick_ff;
  logic [31:0] act_tick_ff;
  logic        act_phase_ff;
  logic [2:0]  code_ff;
  logic        red_blink;
  logic        ctrl_run_ff;
  logic [2:0]  irq_stat_ff;
  logic [2:0]  irq_mask_ff;
  logic        link_d_ff;
  logic        run_d_ff;
  logic        wr_pend_ff;
  logic [7:0]  wr_addr_ff;
  logic [2:0]  nxt_irq_stat;

  // Reset release synchroniser
  always_ff @(posedge CLK_I or negedge RSTN_I) begin
    if (!RSTN_I) begin
      rst_a_ff <= 1'b0;
      rst_n    <= 1'b0;
    end else begin
      rst_a_ff <= 1'b1;
      rst_n    <= rst_a_ff;
    end
  end

  // Power-up step sequencer; holds step four until self-test ends with the CTRL run bit set
  always_ff @(posedge CLK_I or negedge rst_n) begin
    if (!rst_n) begin
      step_ff      <= S_ONE;
      step_tick_ff <= 32'h0;
    end else begin
      case (step_ff)
        S_ONE, S_TWO, S_THREE: begin
          if (step_tick_ff == STEP_CYC - 1) begin
            step_tick_ff <= 32'h0;
            step_ff      <= step_e'(step_ff + 3'h1);
          end else begin
            step_tick_ff <= step_tick_ff + 32'h1;
          end
        end
        S_FOUR: begin
          if (SELFTEST_DONE_I && !SELFTEST_BUSY_I && ctrl_run_ff) begin
            step_ff <= S_RUN;
          end
        end
        S_RUN:   step_ff <= S_RUN;
        default: step_ff <= S_ONE;
      endcase
    end
  end

  // Activity blink divider, free-running
  always_ff @(posedge CLK_I or negedge rst_n) begin
    if (!rst_n) begin
      act_tick_ff  <= 32'h0;
      act_phase_ff <= 1'b0;
    end else if (act_tick_ff == ACT_CYC - 1) begin
      act_tick_ff  <= 32'h0;
      act_phase_ff <= ~act_phase_ff;
    end else begin
      act_tick_ff <= act_tick_ff + 32'h1;
    end
  end

  // Error code sampled every cycle once sequencer reaches normal operation
  always_ff @(posedge CLK_I or negedge rst_n) begin
    if (!rst_n) begin
      code_ff <= CODE_NONE;
    end else if (step_ff == S_RUN) begin
      code_ff <= (FAIL_CODE_I > CODE_FLASH_CRC) ? CODE_NONE : FAIL_CODE_I;
    end
  end

  lamp_blinker #(
    .ON_CYC     (ON_CYC),
    .PAUSE_CYCS (PAUSE_CYCS)
  ) u_blinker (
    .clk_i   (CLK_I),
    .rst_n_i (rst_n),
    .code_i  (code_ff),
    .lamp_o  (red_blink)
  );

  // Lamp drivers
  always_ff @(posedge CLK_I or negedge rst_n) begin
    if (!rst_n) begin
      ACT_LAMP_O      <= 1'b0;
      DUPLEX_LAMP_O   <= 1'b0;
      SPEED_LAMP_O    <= 1'b0;
      SELFTEST_LAMP_O <= 1'b0;
      RUN_LAMP_O      <= 1'b0;
      FAIL_LAMP_O     <= 1'b0;
    end else begin
      case (step_ff)
        S_ONE: begin
          ACT_LAMP_O      <= 1'b0;
          SELFTEST_LAMP_O <= 1'b1;
          RUN_LAMP_O      <= 1'b1;
          FAIL_LAMP_O     <= 1'b1;
          DUPLEX_LAMP_O   <= 1'b0;
          SPEED_LAMP_O    <= 1'b0;
        end
        S_TWO: begin
          ACT_LAMP_O      <= 1'b1;
          SELFTEST_LAMP_O <= 1'b0;
          RUN_LAMP_O      <= 1'b0;
          FAIL_LAMP_O     <= 1'b1;
          DUPLEX_LAMP_O   <= 1'b0;
          SPEED_LAMP_O    <= 1'b0;
        end
        S_THREE: begin
          ACT_LAMP_O      <= 1'b0;
          SELFTEST_LAMP_O <= 1'b1;
          RUN_LAMP_O      <= 1'b1;
          FAIL_LAMP_O     <= 1'b0;
          DUPLEX_LAMP_O   <= 1'b0;
          SPEED_LAMP_O    <= 1'b0;
        end
        S_FOUR: begin
          ACT_LAMP_O      <= 1'b0;
          SELFTEST_LAMP_O <= 1'b0;
          RUN_LAMP_O      <= 1'b1;
          FAIL_LAMP_O     <= 1'b0;
          DUPLEX_LAMP_O   <= 1'b0;
          SPEED_LAMP_O    <= 1'b0;
        end
        default: begin
          ACT_LAMP_O      <= LINK_UP_I && (!TRAFFIC_I || act_phase_ff);
          DUPLEX_LAMP_O   <= LINK_UP_I && FULL_DUPLEX_I;
          SPEED_LAMP_O    <= LINK_UP_I && SPEED_100_I;
          SELFTEST_LAMP_O <= 1'b0;
          RUN_LAMP_O      <= (code_ff == CODE_NONE);
          FAIL_LAMP_O     <= red_blink;
        end
      endcase
    end
  end

  // AHB-Lite slave, zero wait states
  always_ff @(posedge CLK_I or negedge rst_n) begin
    if (!rst_n) begin
      wr_pend_ff <= 1'b0;
      wr_addr_ff <= 8'h0;
      HRDATA     <= 32'h0;
      HREADYOUT  <= 1'b1;
      HRESP      <= 1'b0;
    end else begin
      wr_pend_ff <= HSEL && HREADY && HTRANS[1] && HWRITE;
      wr_addr_ff <= HADDR[7:0];
      HRDATA     <= 32'h0;
      if (HSEL && HREADY && HTRANS[1] && !HWRITE) begin
        case (HADDR[7:0])
          CTRL_OFS:     HRDATA <= {31'h0, ctrl_run_ff};
          STAT_OFS:     HRDATA <= {22'h0, LINK_UP_I, SPEED_100_I,
                                   FULL_DUPLEX_I, code_ff,
                                   1'b0, step_ff};
          IRQ_STAT_OFS: HRDATA <= {29'h0, irq_stat_ff};
          IRQ_MASK_OFS: HRDATA <= {29'h0, irq_mask_ff};
          default:      HRDATA <= 32'h0;
        endcase
      end
    end
  end

  always_ff @(posedge CLK_I or negedge rst_n) begin
    if (!rst_n) begin
      ctrl_run_ff <= CTRL_RST[CTRL_RUN_BIT];
      irq_mask_ff <= IRQ_MASK_RST;
    end else if (wr_pend_ff) begin
      if (wr_addr_ff == CTRL_OFS) ctrl_run_ff <= HWDATA[CTRL_RUN_BIT];
      if (wr_addr_ff == IRQ_MASK_OFS) irq_mask_ff <= HWDATA[2:0];
    end
  end

  // Sticky events; a new event wins over a write-one clear
  always_comb begin
    nxt_irq_stat = irq_stat_ff;
    if (wr_pend_ff && wr_addr_ff == IRQ_STAT_OFS) begin
      nxt_irq_stat = irq_stat_ff & ~HWDATA[2:0];
    end
    if (step_ff == S_RUN && code_ff != CODE_NONE) begin
      nxt_irq_stat[IRQ_FAIL_BIT] = 1'b1;
    end
    if (step_ff == S_RUN && !run_d_ff) nxt_irq_stat[IRQ_RUN_BIT] = 1'b1;
    if (LINK_UP_I != link_d_ff) nxt_irq_stat[IRQ_LINK_BIT] = 1'b1;
  end

  always_ff @(posedge CLK_I or negedge rst_n) begin
    if (!rst_n) begin
      irq_stat_ff <= 3'h0;
      link_d_ff   <= 1'b0;
      run_d_ff    <= 1'b0;
      IRQ_O       <= 1'b0;
    end else begin
      irq_stat_ff <= nxt_irq_stat;
      link_d_ff   <= LINK_UP_I;
      run_d_ff    <= (step_ff == S_RUN);
      IRQ_O       <= |(nxt_irq_stat & irq_mask_ff);
    end
  end

  AST_STEP_ONE_LAMPS: assert property (@(posedge CLK_I) disable iff (!rst_n)
    (rst_n && step_ff == S_ONE) |=> (FAIL_LAMP_O && RUN_LAMP_O
                                     && SELFTEST_LAMP_O))
    else $error("step one lamps wrong");
  AST_STEP_TWO_LAMPS: assert property (@(posedge CLK_I) disable iff (!rst_n)
    (step_ff == S_TWO) |=> (FAIL_LAMP_O && ACT_LAMP_O && !RUN_LAMP_O))
    else $error("step two lamps wrong");
  AST_STEP_THREE_LAMPS: assert property (@(posedge CLK_I) disable iff (!rst_n)
    (step_ff == S_THREE) |=> (!FAIL_LAMP_O && !ACT_LAMP_O && RUN_LAMP_O
                              && SELFTEST_LAMP_O))
    else $error("step three lamps wrong");
  AST_STEP_FOUR_LAMPS: assert property (@(posedge CLK_I) disable iff (!rst_n)
    (step_ff == S_FOUR) |=> (RUN_LAMP_O && !SELFTEST_LAMP_O
                             && !FAIL_LAMP_O && !ACT_LAMP_O))
    else $error("step four lamps wrong");
  AST_NO_LINK_DARK: assert property (@(posedge CLK_I) disable iff (!rst_n)
    (step_ff == S_RUN && !LINK_UP_I) |=> !ACT_LAMP_O)
    else $error("activity lamp lit without link");
  AST_SPEED_FOLLOWS: assert property (@(posedge CLK_I) disable iff (!rst_n)
    (step_ff == S_RUN) |=> (SPEED_LAMP_O == $past(LINK_UP_I && SPEED_100_I)))
    else $error("speed lamp wrong");
  AST_SELFTEST_OFF_RUN: assert property (@(posedge CLK_I) disable iff (!rst_n)
    (step_ff == S_RUN) |=> !SELFTEST_LAMP_O)
    else $error("self-test lamp lit in operation");
  AST_RUN_GREEN: assert property (@(posedge CLK_I) disable iff (!rst_n)
    (step_ff == S_RUN && code_ff == CODE_NONE) [*2] |-> (RUN_LAMP_O
                                                      && !FAIL_LAMP_O))
    else $error("green lamp off or red lit without error");
endmodule
`default_nettype wire

// ---- bench/lamp_viewer.sv ----
`timescale 1ns/10ps
`default_nettype none
module lamp_viewer #(
  parameter int unsigned PAUSE_MIN = 30
) (
  input  wire logic       clk_i,
  input  wire logic       rst_n_i,
  input  wire logic       lamp_i,
  output logic [3:0]      group_o,
  output logic [7:0]      groups_o,
  output logic [7:0]      on_len_o,
  output logic [7:0]      gap_o
);
  logic       prev_ff;
  logic [3:0] cnt_ff;
  logic [7:0] on_ff;
  logic [7:0] dark_ff;

  // Counts red blinks between long dark gaps, as a viewer would
  always_ff @(posedge clk_i or negedge rst_n_i) begin
    if (!rst_n_i) begin
      prev_ff  <= 1'h0;
      cnt_ff   <= 4'h0;
      on_ff    <= 8'h00;
      dark_ff  <= 8'h00;
      group_o  <= 4'h0;
      groups_o <= 8'h00;
      on_len_o <= 8'h00;
      gap_o    <= 8'h00;
    end else begin
      prev_ff <= lamp_i;
      if (lamp_i) begin
        on_ff   <= on_ff + 8'h01;
        dark_ff <= 8'h00;
      end else if (dark_ff != 8'hFF) begin
        dark_ff <= dark_ff + 8'h01;
      end
      if (lamp_i && !prev_ff) begin
        on_ff <= 8'h01;
        if (dark_ff >= PAUSE_MIN) begin
          group_o  <= cnt_ff;
          gap_o    <= dark_ff;
          groups_o <= groups_o + 8'h01;
          cnt_ff   <= 4'h1;
        end else begin
          cnt_ff <= cnt_ff + 4'h1;
        end
      end
      if (!lamp_i && prev_ff) begin
        on_len_o <= on_ff;
      end
    end
  end
endmodule
`default_nettype wire

// ---- bench/network_board_status_lamps_tb.sv ----
`timescale 1ns/10ps
`default_nettype none
module network_board_status_lamps_tb;
  import lamp_pkg::*;
  localparam int unsigned ON_T = 10;
  localparam int unsigned PAUSE_T = 50;
  logic        CLK_I = 1'h0;
  logic        RSTN_I = 1'h0;
  logic        LINK_UP_I = 1'h1;
  logic        TRAFFIC_I = 1'h0;
  logic        FULL_DUPLEX_I = 1'h0;
  logic        SPEED_100_I = 1'h0;
  logic        SELFTEST_BUSY_I = 1'h1;
  logic        SELFTEST_DONE_I = 1'h0;
  logic [2:0]  FAIL_CODE_I = 3'h0;
  logic        HSEL = 1'h0;
  logic [31:0] HADDR = 32'h0;
  logic [1:0]  HTRANS = 2'h0;
  logic        HWRITE = 1'h0;
  logic [31:0] HWDATA = 32'h0;
  logic [31:0] HRDATA;
  logic        HREADYOUT;
  logic        HRESP;
  logic        ACT_LAMP_O;
  logic        DUPLEX_LAMP_O;
  logic        SPEED_LAMP_O;
  logic        SELFTEST_LAMP_O;
  logic        RUN_LAMP_O;
  logic        FAIL_LAMP_O;
  logic        IRQ_O;
  logic [3:0]  grp;
  logic [7:0]  ngrp;
  logic [7:0]  on_len;
  logic [7:0]  gap;
  logic [31:0] rd;
  logic        prev;
  int          err_total = 0;
  int          num_checks = 0;
  int          n;
  wire logic [3:0] pat = {ACT_LAMP_O, SELFTEST_LAMP_O, RUN_LAMP_O,
                          FAIL_LAMP_O};

  always #50 CLK_I = ~CLK_I;

  network_board_status_lamps #(.ON_CYC(ON_T), .PAUSE_CYCS(PAUSE_T),
    .STEP_CYC(20), .ACT_CYC(4)) network_board_status_lamps_i (
    .CLK_I(CLK_I), .RSTN_I(RSTN_I), .LINK_UP_I(LINK_UP_I),
    .TRAFFIC_I(TRAFFIC_I), .FULL_DUPLEX_I(FULL_DUPLEX_I),
    .SPEED_100_I(SPEED_100_I), .SELFTEST_BUSY_I(SELFTEST_BUSY_I),
    .SELFTEST_DONE_I(SELFTEST_DONE_I), .FAIL_CODE_I(FAIL_CODE_I),
    .HSEL(HSEL), .HADDR(HADDR), .HTRANS(HTRANS), .HWRITE(HWRITE),
    .HSIZE(3'h2), .HWDATA(HWDATA), .HREADY(HREADYOUT), .HRDATA(HRDATA),
    .HREADYOUT(HREADYOUT), .HRESP(HRESP), .ACT_LAMP_O(ACT_LAMP_O),
    .DUPLEX_LAMP_O(DUPLEX_LAMP_O), .SPEED_LAMP_O(SPEED_LAMP_O),
    .SELFTEST_LAMP_O(SELFTEST_LAMP_O), .RUN_LAMP_O(RUN_LAMP_O),
    .FAIL_LAMP_O(FAIL_LAMP_O), .IRQ_O(IRQ_O));

  lamp_viewer #(.PAUSE_MIN(30)) lamp_viewer_i (
    .clk_i(CLK_I), .rst_n_i(RSTN_I), .lamp_i(FAIL_LAMP_O), .group_o(grp),
    .groups_o(ngrp), .on_len_o(on_len), .gap_o(gap));

  task automatic chk(input string nm, input logic [31:0] e,
                     input logic [31:0] g);
    num_checks++;
    if (g !== e) begin
      err_total++;
      $display("MISMATCH %s expected %h seen %h", nm, e, g);
    end
  endtask

  task automatic wrap_up();
    $display("checks %0d mismatches %0d", num_checks, err_total);
    if (err_total == 0 && num_checks > 0) $display("verification passed");
    else $display("verification failed");
    $finish;
  endtask

  task automatic cyc(input int k);
    repeat (k) @(posedge CLK_I);
  endtask

  task automatic bus(input logic w, input logic [7:0] a,
                     input logic [31:0] wd, output logic [31:0] r);
    HSEL   <= 1'h1;
    HTRANS <= 2'h2;
    HADDR  <= {24'h0, a};
    HWRITE <= w;
    @(posedge CLK_I);
    while (HREADYOUT !== 1'h1) begin
      @(posedge CLK_I);
    end
    HSEL   <= 1'h0;
    HTRANS <= 2'h0;
    HWDATA <= wd;
    @(posedge CLK_I);
    while (HREADYOUT !== 1'h1) begin
      @(posedge CLK_I);
    end
    r = HRDATA;
    chk("hresp", 32'h0, {31'h0, HRESP});
  endtask

  task automatic rst_seq();
    RSTN_I <= 1'h0;
    cyc(20);
    RSTN_I <= 1'h1;
    cyc(3);
  endtask

  task automatic wait_change();
    logic [3:0] p0;
    int k;
    p0 = pat;
    k = 0;
    while (pat === p0 && k < 100) begin
      @(posedge CLK_I);
      k++;
    end
    chk("lamp change", 32'h1, {31'h0, k < 100});
    cyc(3);
  endtask

  initial begin
    cyc(20000);
    err_total++;
    wrap_up();
  end

  initial begin
    rst_seq();
    cyc(5);
    chk("step1", 32'h7, {29'h0, pat[2:0]});
    wait_change();
    chk("step2", 32'h9, {28'h0, pat});
    wait_change();
    chk("step3", 32'h6, {28'h0, pat});
    wait_change();
    chk("step4", 32'h2, {29'h0, pat[2:0]});
    cyc(40);
    chk("step4 hold", 32'h2, {29'h0, pat[2:0]});
    $display("power-up test done");
    SELFTEST_BUSY_I <= 1'h0;
    SELFTEST_DONE_I <= 1'h1;
    cyc(10);
    chk("normal idle", 32'hA, {28'h0, pat});
    for (int i = 0; i < 4; i++) begin
      FULL_DUPLEX_I <= i[0];
      SPEED_100_I   <= i[1];
      cyc(3);
      chk("duplex", {31'h0, i[0]}, {31'h0, DUPLEX_LAMP_O});
      chk("speed", {31'h0, i[1]}, {31'h0, SPEED_LAMP_O});
    end
    n = 0;
    repeat (30) begin
      @(posedge CLK_I);
      if (FAIL_LAMP_O !== 1'h0) n++;
    end
    chk("red dark", 32'h0, n);
    TRAFFIC_I <= 1'h1;
    cyc(2);
    n = 0;
    prev = ACT_LAMP_O;
    repeat (20) begin
      @(posedge CLK_I);
      if (ACT_LAMP_O !== prev) n++;
      prev = ACT_LAMP_O;
    end
    chk("act blink", 32'h1, {31'h0, n >= 3});
    LINK_UP_I <= 1'h0;
    TRAFFIC_I <= 1'h0;
    cyc(3);
    chk("act no link", 32'h0, {31'h0, ACT_LAMP_O});
    $display("normal run test done");
    bus(1'h0, CTRL_OFS, 32'h0, rd);
    chk("ctrl reset", CTRL_RST, rd);
    bus(1'h0, 8'h10, 32'h0, rd);
    chk("unmapped", 32'h0, rd);
    bus(1'h0, IRQ_MASK_OFS, 32'h0, rd);
    chk("mask reset", {29'h0, IRQ_MASK_RST}, rd);
    bus(1'h0, STAT_OFS, 32'h0, rd);
    chk("stat", 32'h180, rd & 32'h3F0);
    bus(1'h0, IRQ_STAT_OFS, 32'h0, rd);
    chk("irq stat", 32'h6, rd);
    chk("irq masked", 32'h0, {31'h0, IRQ_O});
    bus(1'h1, IRQ_MASK_OFS, 32'h2, rd);
    cyc(3);
    chk("irq on", 32'h1, {31'h0, IRQ_O});
    bus(1'h1, IRQ_STAT_OFS, 32'h2, rd);
    cyc(3);
    chk("irq off", 32'h0, {31'h0, IRQ_O});
    bus(1'h0, IRQ_STAT_OFS, 32'h0, rd);
    chk("irq w1c", 32'h4, rd);
    $display("register test done");
    for (int c = 1; c <= 6; c++) begin
      FAIL_CODE_I <= c[2:0];
      rst_seq();
      n = 0;
      while (ngrp < 8'h02 && n < 1000) begin
        @(posedge CLK_I);
        n++;
      end
      chk("group wait", 32'h1, {31'h0, n < 1000});
      chk("blinks", c, {28'h0, grp});
      chk("on len", ON_T, {24'h0, on_len});
      chk("pause", 32'h1, {31'h0, gap >= PAUSE_T});
    end
    bus(1'h0, IRQ_STAT_OFS, 32'h0, rd);
    chk("fail irq", 32'h1, {31'h0, rd[IRQ_FAIL_BIT]});
    $display("error code test done");
    wrap_up();
  end
endmodule
`default_nettype wire
